/* File: fam_top.sv */
// Flow alarm monitor: registers, limit compare, delays, latch and relay drive
`timescale 1ns/1ps
module fam_top #(
	parameter int TICK_CYCLES = fam_pkg::TICK_CYCLES
) (
	input  wire logic        clock,
	input  wire logic        resetn,
	input  wire logic [3:0]  addr,
	input  wire logic [15:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic      [15:0] rdata,
	input  wire logic [10:0] flow_pfs,
	output logic             relay_output,
	output logic             screen_low_flag,
	output logic             screen_high_flag,
	output logic             status_led,
	output logic             irq
);
	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	initial begin
		if (TICK_CYCLES < 1) $error("fam_top: TICK_CYCLES must be at least 1");
	end

	fam_cfg_if cfg ();
	logic tick;

	fam_tick_div #(.CYCLES(TICK_CYCLES)) u_tick (
		.clock  (clock),
		.resetn (resetn),
		.tick   (tick)
	);

	// ------------------------------------------------------------------
	// Register file
	// ------------------------------------------------------------------
	logic        enable_ff;
	logic        latch_ff;
	logic [1:0]  sel_ff;
	logic [10:0] low_ff;
	logic [10:0] high_ff;
	logic [11:0] act_ff;
	logic [11:0] pon_ff;
	logic [2:0]  irq_stat_ff;
	logic [2:0]  irq_mask_ff;

	function automatic logic [10:0] clamp_lim(input logic [15:0] v);
		return (v > 16'(fam_pkg::LIMIT_MAX)) ? fam_pkg::LIMIT_MAX : v[10:0];
	endfunction

	function automatic logic [11:0] clamp_dly(input logic [15:0] v);
		return (v > 16'(fam_pkg::DELAY_MAX_S)) ? fam_pkg::DELAY_MAX_S : v[11:0];
	endfunction

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			enable_ff <= 1'b0;
			latch_ff  <= 1'b0;
			sel_ff    <= fam_pkg::SEL_EITHER;
			low_ff    <= fam_pkg::LOW_LIM_RST;
			high_ff   <= fam_pkg::HIGH_LIM_RST;
			act_ff    <= fam_pkg::DELAY_RST;
			pon_ff    <= fam_pkg::DELAY_RST;
		end else if (wr) begin
			unique case (addr)
				fam_pkg::ADDR_CTRL: begin
					enable_ff <= wdata[fam_pkg::CTRL_EN_BIT];
					latch_ff  <= wdata[fam_pkg::CTRL_LATCH_BIT];
					sel_ff    <= wdata[fam_pkg::CTRL_SEL_LSB +: 2];
				end
				fam_pkg::ADDR_LOW_LIM:  low_ff  <= clamp_lim(wdata);
				fam_pkg::ADDR_HIGH_LIM: high_ff <= clamp_lim(wdata);
				fam_pkg::ADDR_ACT_DLY:  act_ff  <= clamp_dly(wdata);
				fam_pkg::ADDR_PON_DLY:  pon_ff  <= clamp_dly(wdata);
				default: ;
			endcase
		end
	end

	assign cfg.enable    = enable_ff;
	assign cfg.latch     = latch_ff;
	assign cfg.relay_sel = sel_ff;
	assign cfg.low_lim   = low_ff;
	assign cfg.high_lim  = high_ff;
	assign cfg.act_dly   = act_ff;
	assign cfg.pon_dly   = pon_ff;

	// ------------------------------------------------------------------
	// Power-on hold-off
	// ------------------------------------------------------------------
	logic [11:0] pon_cnt_ff;
	logic        armed_ff;

	// Counts seconds since reset; a later shorter setting arms at once
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			pon_cnt_ff <= '0;
			armed_ff   <= 1'b0;
		end else if (!armed_ff) begin
			if (pon_cnt_ff >= cfg.pon_dly) begin
				armed_ff <= 1'b1;
			end else if (tick) begin
				pon_cnt_ff <= pon_cnt_ff + 12'h001;
			end
		end
	end

	// ------------------------------------------------------------------
	// Limit compare
	// ------------------------------------------------------------------
	logic active;
	logic cond_low;
	logic cond_high;
	logic cond_any;

	assign active    = cfg.enable && armed_ff;
	assign cond_low  = active && (flow_pfs <= cfg.low_lim);
	assign cond_high = active && (flow_pfs >= cfg.high_lim);
	assign cond_any  = cond_low || cond_high;

	// ------------------------------------------------------------------
	// Action delay
	// ------------------------------------------------------------------
	logic [11:0] act_cnt_ff;
	logic        valid_ff;
	logic        vlow_ff;
	logic        vhigh_ff;

	// Seconds counted on the one-second enable, so a delay of N means
	// between N-1 and N whole seconds: the tick phase is not aligned.
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			act_cnt_ff <= '0;
			valid_ff   <= 1'b0;
		end else if (!cond_any) begin
			act_cnt_ff <= '0;
			valid_ff   <= 1'b0;
		end else if (act_cnt_ff >= cfg.act_dly) begin
			valid_ff <= 1'b1;
		end else if (tick) begin
			act_cnt_ff <= act_cnt_ff + 12'h001;
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			vlow_ff  <= 1'b0;
			vhigh_ff <= 1'b0;
		end else begin
			vlow_ff  <= cond_low && (act_cnt_ff >= cfg.act_dly);
			vhigh_ff <= cond_high && (act_cnt_ff >= cfg.act_dly);
		end
	end

	// ------------------------------------------------------------------
	// Relay drive and latch
	// ------------------------------------------------------------------
	logic relay_evt;
	logic latched_ff;

	always_comb begin
		unique case (cfg.relay_sel)
			fam_pkg::SEL_LOW:  relay_evt = vlow_ff;
			fam_pkg::SEL_HIGH: relay_evt = vhigh_ff;
			fam_pkg::SEL_EITHER: relay_evt = vlow_ff || vhigh_ff;
			default: relay_evt = 1'b0;
		endcase
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			latched_ff <= 1'b0;
		end else if (!cfg.enable || !cfg.latch) begin
			latched_ff <= 1'b0;
		end else if (relay_evt) begin
			latched_ff <= 1'b1;
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			relay_output     <= 1'b0;
			screen_low_flag  <= 1'b0;
			screen_high_flag <= 1'b0;
			status_led       <= 1'b0;
		end else begin
			relay_output     <= cfg.enable && (relay_evt || latched_ff);
			screen_low_flag  <= vlow_ff;
			screen_high_flag <= vhigh_ff;
			status_led       <= vlow_ff || vhigh_ff;
		end
	end

	// ------------------------------------------------------------------
	// Interrupts: low, high, relay-on events; write one to clear
	// ------------------------------------------------------------------
	logic [2:0] evt;
	logic       relay_q_ff;

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			relay_q_ff <= 1'b0;
		end else begin
			relay_q_ff <= relay_output;
		end
	end

	assign evt = {relay_output && !relay_q_ff, vhigh_ff, vlow_ff};

	// Set wins over a clear in the same cycle
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			irq_stat_ff <= '0;
			irq_mask_ff <= '0;
		end else begin
			irq_stat_ff <= (irq_stat_ff & ~((wr && addr == fam_pkg::ADDR_IRQ_STAT)
				? wdata[2:0] : 3'h0)) | evt;
			if (wr && addr == fam_pkg::ADDR_IRQ_MASK) begin
				irq_mask_ff <= wdata[2:0];
			end
		end
	end

	assign irq = |(irq_stat_ff & irq_mask_ff);

	// ------------------------------------------------------------------
	// Read port
	// ------------------------------------------------------------------
	logic [15:0] nxt_rdata;

	always_comb begin
		nxt_rdata = 16'h0000;
		unique case (addr)
			fam_pkg::ADDR_CTRL:     nxt_rdata = {12'h000, sel_ff, latch_ff, enable_ff};
			fam_pkg::ADDR_LOW_LIM:  nxt_rdata = {5'h00, low_ff};
			fam_pkg::ADDR_HIGH_LIM: nxt_rdata = {5'h00, high_ff};
			fam_pkg::ADDR_ACT_DLY:  nxt_rdata = {4'h0, act_ff};
			fam_pkg::ADDR_PON_DLY:  nxt_rdata = {4'h0, pon_ff};
			fam_pkg::ADDR_STATUS:   nxt_rdata = {11'h000, armed_ff, relay_output,
				valid_ff, vhigh_ff, vlow_ff};
			fam_pkg::ADDR_IRQ_STAT: nxt_rdata = {13'h0000, irq_stat_ff};
			fam_pkg::ADDR_IRQ_MASK: nxt_rdata = {13'h0000, irq_mask_ff};
			fam_pkg::ADDR_FLOW:     nxt_rdata = {5'h00, flow_pfs};
			default:                nxt_rdata = 16'h0000;
		endcase
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			rdata <= 16'h0000;
		end else begin
			rdata <= rd ? nxt_rdata : 16'h0000;
		end
	end

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	sequence dis_s;
		!cfg.enable;
	endsequence

	disabled_quiet_a: assert property (@(posedge clock) disable iff (!resetn)
		dis_s ##1 dis_s ##1 dis_s |-> !relay_output && !status_led)
		else $error("alarm output while disabled");

	high_cmp_a: assert property (@(posedge clock) disable iff (!resetn)
		cond_high |-> flow_pfs >= cfg.high_lim)
		else $error("high condition without reading at limit");

	low_flag_a: assert property (@(posedge clock) disable iff (!resetn)
		cond_low && cfg.act_dly == 12'h000 |-> ##1 ##1 screen_low_flag || !$past(cond_low))
		else $error("low flag missing");

	hold_off_a: assert property (@(posedge clock) disable iff (!resetn)
		!armed_ff |-> !vlow_ff && !vhigh_ff ##0 !valid_ff)
		else $error("alarm active during power-on hold-off");

	delay_wait_a: assert property (@(posedge clock) disable iff (!resetn)
		valid_ff |-> act_cnt_ff >= cfg.act_dly)
		else $error("alarm validated early");

	immediate_a: assert property (@(posedge clock) disable iff (!resetn)
		cond_any && cfg.act_dly == 12'h000 && $stable(cfg.act_dly) |-> ##1 valid_ff || !cond_any)
		else $error("zero delay not immediate");

	latch_hold_a: assert property (@(posedge clock) disable iff (!resetn)
		latched_ff && cfg.enable && cfg.latch |-> ##1 relay_output)
		else $error("latched relay dropped");

	unlatch_clear_a: assert property (@(posedge clock) disable iff (!resetn)
		!cfg.enable |-> ##1 !latched_ff && act_cnt_ff == 12'h000)
		else $error("disable did not clear latch or counter");

	sel_high_a: assert property (@(posedge clock) disable iff (!resetn)
		cfg.relay_sel == fam_pkg::SEL_HIGH && !cfg.latch && $stable(cfg.relay_sel)
		&& $stable(cfg.latch) |-> ##1 relay_output == ($past(cfg.enable) && $past(vhigh_ff)))
		else $error("high-assigned relay mismatch");

	sel_low_a: assert property (@(posedge clock) disable iff (!resetn)
		cfg.relay_sel == fam_pkg::SEL_LOW && !cfg.latch && $stable(cfg.relay_sel)
		&& $stable(cfg.latch) |-> ##1 relay_output == ($past(cfg.enable) && $past(vlow_ff)))
		else $error("low-assigned relay mismatch");

	led_a: assert property (@(posedge clock) disable iff (!resetn)
		##1 status_led == ($past(vlow_ff) || $past(vhigh_ff)))
		else $error("status led mismatch");
endmodule

/* File: fam_pkg.sv */
// Package: register map, field layout, reset values and timing for the flow alarm monitor
package fam_pkg;
	// ------------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------------
	localparam logic [3:0] ADDR_CTRL     = 4'h0;
	localparam logic [3:0] ADDR_LOW_LIM  = 4'h1;
	localparam logic [3:0] ADDR_HIGH_LIM = 4'h2;
	localparam logic [3:0] ADDR_ACT_DLY  = 4'h3;
	localparam logic [3:0] ADDR_PON_DLY  = 4'h4;
	localparam logic [3:0] ADDR_STATUS   = 4'h5;
	localparam logic [3:0] ADDR_IRQ_STAT = 4'h6;
	localparam logic [3:0] ADDR_IRQ_MASK = 4'h7;
	localparam logic [3:0] ADDR_FLOW     = 4'h8;

	// ------------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------------
	localparam int CTRL_EN_BIT    = 0;
	localparam int CTRL_LATCH_BIT = 1;
	localparam int CTRL_SEL_LSB   = 2;
	localparam int ST_LOW_BIT     = 0;
	localparam int ST_HIGH_BIT    = 1;
	localparam int ST_VALID_BIT   = 2;
	localparam int ST_RELAY_BIT   = 3;
	localparam int ST_ARMED_BIT   = 4;

	// Relay assignment: 0 none, 1 low, 2 high, 3 either
	localparam logic [1:0] SEL_NONE  = 2'h0;
	localparam logic [1:0] SEL_LOW   = 2'h1;
	localparam logic [1:0] SEL_HIGH  = 2'h2;
	localparam logic [1:0] SEL_EITHER = 2'h3;

	// ------------------------------------------------------------------
	// Reset values and limits
	// ------------------------------------------------------------------
	localparam logic [10:0] LIMIT_MAX       = 11'h3E8;
	localparam logic [10:0] LOW_LIM_RST     = 11'h000;
	localparam logic [10:0] HIGH_LIM_RST    = 11'h3E8;
	localparam logic [11:0] DELAY_MAX_S     = 12'hE10;
	localparam logic [11:0] DELAY_RST       = 12'h000;

	// ------------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------------
	localparam int CLK_MHZ      = 100;
	localparam int TICK_S       = 1;
	localparam int TICK_CYCLES  = CLK_MHZ * 1000000 * TICK_S;
endpackage

/* File: fam_cfg_if.sv */
// Interface: configuration carried from the register file to the alarm core
`timescale 1ns/1ps
interface fam_cfg_if;
	logic        enable;
	logic        latch;
	logic [1:0]  relay_sel;
	logic [10:0] low_lim;
	logic [10:0] high_lim;
	logic [11:0] act_dly;
	logic [11:0] pon_dly;
	modport regs (output enable, latch, relay_sel, low_lim, high_lim, act_dly, pon_dly);
	modport core (input enable, latch, relay_sel, low_lim, high_lim, act_dly, pon_dly);
endinterface

/* File: fam_tick_div.sv */
// One-second enable pulse divider
`timescale 1ns/1ps
module fam_tick_div #(
	parameter int CYCLES = fam_pkg::TICK_CYCLES
) (
	input  wire logic clock,
	input  wire logic resetn,
	output logic      tick
);
	localparam int W = $clog2(CYCLES + 1);
	logic [W-1:0] cnt_ff;

	initial begin
		if (CYCLES < 1) $error("fam_tick_div: CYCLES must be at least 1");
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			cnt_ff <= '0;
			tick   <= 1'b0;
		end else if (cnt_ff == W'(CYCLES - 1)) begin
			cnt_ff <= '0;
			tick   <= 1'b1;
		end else begin
			cnt_ff <= cnt_ff + 1'b1;
			tick   <= 1'b0;
		end
	end
endmodule

/* File: fam_relay_model.sv */
// Model of the relay contact, the info screen letter and the status lamp
`timescale 1ns/1ps
module fam_relay_model (
	input  wire logic       clock,
	input  wire logic       resetn,
	input  wire logic       relay_output,
	input  wire logic       screen_low_flag,
	input  wire logic       screen_high_flag,
	input  wire logic       status_led,
	output logic            contact_closed,
	output logic      [7:0] shown_char,
	output logic            lamp_lit
);
	// ------------------------------------------------------------------
	// Load side: one cycle of switching lag, as a real contact is slower
	// ------------------------------------------------------------------
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			contact_closed <= 1'b0;
			lamp_lit       <= 1'b0;
		end else begin
			contact_closed <= relay_output;
			lamp_lit       <= status_led;
		end
	end

	// Low wins if both flags are ever seen together
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			shown_char <= 8'h20;
		end else if (screen_low_flag) begin
			shown_char <= 8'h4C;
		end else if (screen_high_flag) begin
			shown_char <= 8'h48;
		end else begin
			shown_char <= 8'h20;
		end
	end
endmodule

/* File: flow_alarm_monitor_tb.sv */
// Self-checking testbench of the flow alarm monitor
`timescale 1ns/1ps
module flow_alarm_monitor_tb;
	localparam int TICKS = 10;
	logic        clock;
	logic        resetn;
	logic [3:0]  addr;
	logic [15:0] wdata;
	logic        wr;
	logic        rd;
	logic [15:0] rdata;
	logic [10:0] flow_pfs;
	logic        relay_output;
	logic        screen_low_flag;
	logic        screen_high_flag;
	logic        status_led;
	logic        irq;
	logic        contact_closed;
	logic [7:0]  shown_char;
	logic        lamp_lit;
	int          err_total;
	int          samples_checked;
	int          n;

	fam_top #(.TICK_CYCLES(TICKS)) i_dut (
		.clock(clock), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .flow_pfs(flow_pfs), .relay_output(relay_output),
		.screen_low_flag(screen_low_flag), .screen_high_flag(screen_high_flag),
		.status_led(status_led), .irq(irq)
	);

	fam_relay_model i_load (
		.clock(clock), .resetn(resetn), .relay_output(relay_output),
		.screen_low_flag(screen_low_flag), .screen_high_flag(screen_high_flag),
		.status_led(status_led), .contact_closed(contact_closed),
		.shown_char(shown_char), .lamp_lit(lamp_lit)
	);

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	always #5 clock = ~clock;

	task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic complete_run;
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic bus_wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clock);
		wr    <= 1'b1;
		addr  <= a;
		wdata <= d;
		@(posedge clock);
		wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic bus_rd(input logic [3:0] a, input logic [15:0] exp);
		@(posedge clock);
		rd   <= 1'b1;
		addr <= a;
		@(posedge clock);
		rd <= 1'b0;
		#1;
		check("rdata", rdata, exp);
	endtask

	task automatic set_flow(input logic [10:0] v);
		@(posedge clock);
		flow_pfs <= v;
	endtask

	// Outputs settle two cycles after a cause, the load model one more
	task automatic settle;
		repeat (4) @(posedge clock);
		#1;
	endtask

	// Packs relay, lamp, low flag, high flag
	task automatic outs(input logic [3:0] exp);
		check("outputs", {12'h000, relay_output, status_led, screen_low_flag, screen_high_flag},
			{12'h000, exp});
		check("load", {13'h0000, contact_closed, lamp_lit, 1'b0}, {13'h0000, exp[3:2], 1'b0});
	endtask

	initial begin
		repeat (20000) @(posedge clock);
		err_total++;
		complete_run();
	end

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial begin
		clock = 1'b0;
		resetn = 1'b0;
		addr = 4'h0;
		wdata = 16'h0000;
		wr = 1'b0;
		rd = 1'b0;
		flow_pfs = 11'h1F4;
		err_total = 0;
		samples_checked = 0;
		repeat (20) @(posedge clock);
		resetn <= 1'b1;
		bus_rd(fam_pkg::ADDR_CTRL, 16'h000C);
		bus_rd(fam_pkg::ADDR_LOW_LIM, 16'h0000);
		bus_rd(fam_pkg::ADDR_HIGH_LIM, 16'h03E8);
		bus_rd(fam_pkg::ADDR_ACT_DLY, 16'h0000);
		bus_rd(fam_pkg::ADDR_PON_DLY, 16'h0000);
		bus_rd(fam_pkg::ADDR_IRQ_MASK, 16'h0000);
		bus_rd(4'h9, 16'h0000);
		bus_rd(fam_pkg::ADDR_FLOW, 16'h01F4);
		bus_rd(fam_pkg::ADDR_STATUS, 16'h0010);
		// Both limits crossed while disabled
		set_flow(11'h000);
		settle();
		outs(4'h0);
		set_flow(11'h3E8);
		settle();
		outs(4'h0);
		// Out-of-range settings are clamped
		bus_wr(fam_pkg::ADDR_HIGH_LIM, 16'h07FF);
		bus_rd(fam_pkg::ADDR_HIGH_LIM, 16'h03E8);
		bus_wr(fam_pkg::ADDR_ACT_DLY, 16'hFFFF);
		bus_rd(fam_pkg::ADDR_ACT_DLY, 16'h0E10);
		bus_wr(fam_pkg::ADDR_ACT_DLY, 16'h0000);
		bus_wr(fam_pkg::ADDR_LOW_LIM, 16'h0064);
		bus_wr(fam_pkg::ADDR_HIGH_LIM, 16'h0384);
		bus_wr(fam_pkg::ADDR_IRQ_MASK, 16'h0001);
		set_flow(11'h1F4);
		bus_wr(fam_pkg::ADDR_CTRL, 16'h000D);
		settle();
		outs(4'h0);
		check("irq", {15'h0000, irq}, 16'h0000);
		// Reading equal to the low limit
		set_flow(11'h064);
		settle();
		outs(4'hE);
		check("char", {8'h00, shown_char}, 16'h004C);
		check("irq", {15'h0000, irq}, 16'h0001);
		bus_rd(fam_pkg::ADDR_STATUS, 16'h001D);
		set_flow(11'h1F4);
		settle();
		outs(4'h0);
		check("irq", {15'h0000, irq}, 16'h0001);
		bus_rd(fam_pkg::ADDR_IRQ_STAT, 16'h0005);
		bus_wr(fam_pkg::ADDR_IRQ_STAT, 16'h0007);
		bus_rd(fam_pkg::ADDR_IRQ_STAT, 16'h0000);
		check("irq", {15'h0000, irq}, 16'h0000);
		// Reading equal to the high limit; high event is masked
		set_flow(11'h384);
		settle();
		outs(4'hD);
		check("char", {8'h00, shown_char}, 16'h0048);
		check("irq", {15'h0000, irq}, 16'h0000);
		bus_rd(fam_pkg::ADDR_STATUS, 16'h001E);
		bus_rd(fam_pkg::ADDR_IRQ_STAT, 16'h0006);
		// Every relay assignment against both events
		for (int s = 0; s < 4; s++) begin
			bus_wr(fam_pkg::ADDR_CTRL, {12'h000, s[1:0], 2'b01});
			set_flow(11'h032);
			settle();
			outs({s[0], 3'b110});
			set_flow(11'h3B6);
			settle();
			outs({s[1], 3'b101});
		end
		// Latched relay outlives the condition
		set_flow(11'h1F4);
		bus_wr(fam_pkg::ADDR_CTRL, 16'h000F);
		set_flow(11'h032);
		settle();
		set_flow(11'h1F4);
		settle();
		check("relay", {15'h0000, relay_output}, 16'h0001);
		check("lowflag", {15'h0000, screen_low_flag}, 16'h0000);
		bus_wr(fam_pkg::ADDR_CTRL, 16'h000D);
		settle();
		check("relay", {15'h0000, relay_output}, 16'h0000);
		bus_wr(fam_pkg::ADDR_CTRL, 16'h000F);
		set_flow(11'h032);
		settle();
		bus_wr(fam_pkg::ADDR_CTRL, 16'h000E);
		settle();
		outs(4'h0);
		// Action delay of two seconds at TICKS cycles per second
		set_flow(11'h1F4);
		bus_wr(fam_pkg::ADDR_ACT_DLY, 16'h0002);
		bus_wr(fam_pkg::ADDR_CTRL, 16'h000D);
		set_flow(11'h032);
		settle();
		outs(4'h0);
		n = 0;
		while (screen_low_flag !== 1'b1 && n < 3 * TICKS) begin
			@(posedge clock);
			#1;
			n++;
		end
		check("lowflag", {15'h0000, screen_low_flag}, 16'h0001);
		check("early", {15'h0000, n + 4 < TICKS}, 16'h0000);
		check("late", {15'h0000, n + 4 > 2 * TICKS + 2}, 16'h0000);
		settle();
		outs(4'hE);
		// Reset in mid-run drops a latched relay at once
		bus_wr(fam_pkg::ADDR_CTRL, 16'h000F);
		settle();
		check("relay", {15'h0000, relay_output}, 16'h0001);
		@(posedge clock);
		resetn <= 1'b0;
		repeat (3) @(posedge clock);
		#1;
		outs(4'h0);
		@(posedge clock);
		resetn <= 1'b1;
		bus_rd(fam_pkg::ADDR_CTRL, 16'h000C);
		bus_rd(fam_pkg::ADDR_STATUS, 16'h0010);
		bus_rd(fam_pkg::ADDR_IRQ_STAT, 16'h0000);
		settle();
		outs(4'h0);
		complete_run();
	end
endmodule
